// ### rtl/atc_comparator.sv
/*
 Analog threshold comparator: signed or absolute net difference of two
 metered values, level or rate comparison against a per-unit pickup
 with percentage hysteresis, pickup and reset delays, and interrupt.
 Assumes operand values arrive synchronous with a one-cycle sample
 strobe, each carrying its quantity type and its per-unit base.
*/
// Added by the designer: the register offsets and the address-and-strobe port.
//
// Summary of operation
// - Positive operand Off counts as zero
// - Operating signal is plus minus minus operand
// - No selected operand: pickup and operate never assert
// - Mismatched operand types: element does not operate
// - Signed mode uses difference with sign
// - Absolute mode uses difference magnitude
// - Level mode compares signal itself
// - Delta mode compares change over interval
// - Over picks up above threshold
// - Under picks up below threshold
// - Signed arithmetic for signal and threshold
// - Hysteresis width is percent of pickup
// - Fixed per-unit bases for fixed quantities
// - Milliamp base is larger transducer maximum
// - Current, voltage, power base is larger nominal
// - Interval settings used only in delta mode
// - Pickup delay asserts, reset delay deasserts
`timescale 1ns/1ps
`default_nettype none
module atc_comparator (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sample_stb,
    input wire atc_pkg::atc_operand_t op_plus,
    input wire atc_pkg::atc_operand_t op_minus,
    input wire atc_pkg::atc_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    output logic pickup_flag,
    output logic operate_flag,
    output logic dropout_flag,
    output logic irq
);
    import atc_pkg::*;

    // ==================================================
    // State
    typedef struct packed {
        logic [31:0] opsel;
        logic [31:0] mode;
        logic signed [31:0] pickup;
        logic [7:0] hyst;
        logic [15:0] interval;
        logic [15:0] pkp_dly;
        logic [15:0] rst_dly;
        logic [15:0] cmp_base;
        logic [ATC_IRQ_W-1:0] irq_stat;
        logic [ATC_IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic signed [31:0] opval;
        logic [ATC_HIST_DEPTH-1:0][31:0] hist;
        logic [3:0] wptr;
        logic [15:0] tick_cnt;
        logic [15:0] unit_cnt;
        logic [15:0] dly_cnt;
        atc_state_t st;
        logic pkp;
        logic op;
        logic drop;
        logic irq;
    } atc_reg_t;

    atc_reg_t r;
    atc_reg_t next_r;

    logic signed [31:0] plus_v;
    logic signed [31:0] minus_v;
    logic signed [32:0] diff;
    logic signed [31:0] opsig;
    logic signed [31:0] qty;
    logic signed [47:0] band_w;
    logic signed [31:0] band;
    logic signed [31:0] thr_drop;
    logic valid;
    logic picked;
    logic dropped;
    logic tick;
    logic unit_tick;
    logic [15:0] base_sel;
    logic [15:0] qty_idx;
    logic [3:0] old_idx;

    // ==================================================
    // Operating signal
    always_comb begin
        plus_v = (op_plus.qtype == ATC_Q_OFF) ? 32'sh0 : op_plus.value;
        minus_v = (op_minus.qtype == ATC_Q_OFF) ? 32'sh0
                                                 : op_minus.value;
        diff = 33'(plus_v) - 33'(minus_v);
        if (r.mode[ATC_MODE_ABS_BIT] && diff < 0) begin
            opsig = 32'(-diff);
        end else begin
            opsig = 32'(diff);
        end
        // Operator off requires at least one named value
        valid = (op_plus.qtype != ATC_Q_OFF)
                || (op_minus.qtype != ATC_Q_OFF);
        if (op_plus.qtype != ATC_Q_OFF && op_minus.qtype != ATC_Q_OFF
                && op_plus.qtype != op_minus.qtype) begin
            valid = 1'b0;
        end
    end

    // ==================================================
    // Per-unit base, reported to software for scaling the pickup
    always_comb begin
        atc_qtype_t qt;
        qt = (op_plus.qtype != ATC_Q_OFF) ? op_plus.qtype : op_minus.qtype;
        case (qt)
            ATC_Q_FREQ, ATC_Q_ANGLE, ATC_Q_PF, ATC_Q_RTD: begin
                base_sel = ATC_RST_BASE;
            end
            ATC_Q_DCMA: begin
                base_sel = (op_plus.base > op_minus.base) ? op_plus.base
                                                          : op_minus.base;
            end
            ATC_Q_CURR, ATC_Q_VOLT, ATC_Q_POWER: begin
                base_sel = (op_plus.base > op_minus.base) ? op_plus.base
                                                          : op_minus.base;
            end
            default: begin
                base_sel = ATC_RST_BASE;
            end
        endcase
    end

    // ==================================================
    // Level or delta quantity and threshold
    always_comb begin
        qty_idx = 16'(r.wptr) - r.interval;
        old_idx = qty_idx[3:0];
        if (r.mode[ATC_MODE_DELTA_BIT]) begin
            qty = opsig - signed'(r.hist[old_idx]);
        end else begin
            qty = opsig;
        end
        band_w = 48'(r.pickup) * 48'(signed'({1'b0, r.hyst}));
        band_w = band_w / 48'sd100;
        band = (band_w < 0) ? 32'(-band_w) : 32'(band_w);
        if (r.mode[ATC_MODE_UNDER_BIT]) begin
            picked = qty < r.pickup;
            thr_drop = r.pickup + band;
            dropped = qty > thr_drop;
        end else begin
            picked = qty > r.pickup;
            thr_drop = r.pickup - band;
            dropped = qty < thr_drop;
        end
        tick = (r.tick_cnt == 16'(ATC_TICK_CYC - 1));
        unit_tick = tick && (!r.mode[ATC_MODE_UNIT_BIT]
                             || r.unit_cnt == 16'(ATC_MS_US - 1));
    end

    // ==================================================
    // Next state
    always_comb begin
        logic [ATC_IRQ_W-1:0] ev;
        next_r = r;
        ev = '0;
        next_r.rdata = 32'h0000_0000;
        next_r.tick_cnt = tick ? 16'h0000 : r.tick_cnt + 16'h0001;
        if (tick) begin
            next_r.unit_cnt = (r.unit_cnt == 16'(ATC_MS_US - 1))
                              ? 16'h0000 : r.unit_cnt + 16'h0001;
        end
        // History takes the last sample each unit; strobes need not align
        if (unit_tick) begin
            next_r.hist[r.wptr] = r.opval;
            next_r.wptr = r.wptr + 4'h1;
        end
        if (sample_stb) begin
            next_r.opval = opsig;
            next_r.cmp_base = base_sel;
        end
        case (r.st)
            ATC_ST_IDLE: begin
                if (valid && picked && sample_stb) begin
                    next_r.st = ATC_ST_PKP;
                    next_r.dly_cnt = 16'h0000;
                    ev[ATC_IRQ_PKP_BIT] = 1'b1;
                end
            end
            ATC_ST_PKP: begin
                if (!valid || dropped) begin
                    next_r.st = ATC_ST_IDLE;
                end else if (r.dly_cnt >= r.pkp_dly) begin
                    next_r.st = ATC_ST_OP;
                    ev[ATC_IRQ_OP_BIT] = 1'b1;
                end else if (tick) begin
                    next_r.dly_cnt = r.dly_cnt + 16'h0001;
                end
            end
            ATC_ST_OP: begin
                if (!valid || dropped) begin
                    next_r.st = ATC_ST_DROP;
                    next_r.dly_cnt = 16'h0000;
                    ev[ATC_IRQ_DROP_BIT] = 1'b1;
                end
            end
            ATC_ST_DROP: begin
                if (valid && !dropped) begin
                    next_r.st = ATC_ST_OP;
                end else if (r.dly_cnt >= r.rst_dly) begin
                    next_r.st = ATC_ST_IDLE;
                    ev[ATC_IRQ_RST_BIT] = 1'b1;
                end else if (tick) begin
                    next_r.dly_cnt = r.dly_cnt + 16'h0001;
                end
            end
            default: begin
                next_r.st = ATC_ST_IDLE;
            end
        endcase
        // Pickup and operate forced low whenever the operands are unusable
        next_r.pkp = valid && (next_r.st != ATC_ST_IDLE);
        next_r.op = valid && (next_r.st inside {ATC_ST_OP, ATC_ST_DROP});
        next_r.drop = !(next_r.pkp);
        if (bus_req.wr) begin
            case (bus_req.addr)
                ATC_ADDR_OPSEL: next_r.opsel = bus_req.wdata;
                ATC_ADDR_MODE: next_r.mode = bus_req.wdata;
                ATC_ADDR_PICKUP: next_r.pickup = bus_req.wdata;
                ATC_ADDR_HYST: next_r.hyst = bus_req.wdata[7:0];
                ATC_ADDR_INTERVAL: next_r.interval = bus_req.wdata[15:0];
                ATC_ADDR_PKP_DLY: next_r.pkp_dly = bus_req.wdata[15:0];
                ATC_ADDR_RST_DLY: next_r.rst_dly = bus_req.wdata[15:0];
                ATC_ADDR_IRQ_STAT: begin
                    next_r.irq_stat = r.irq_stat
                                      & ~bus_req.wdata[ATC_IRQ_W-1:0];
                end
                ATC_ADDR_IRQ_MASK: begin
                    next_r.irq_mask = bus_req.wdata[ATC_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Set beats clear in the same cycle
        next_r.irq_stat = next_r.irq_stat | ev;
        next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
        if (bus_req.rd) begin
            case (bus_req.addr)
                ATC_ADDR_OPSEL: next_r.rdata = r.opsel;
                ATC_ADDR_MODE: next_r.rdata = r.mode;
                ATC_ADDR_PICKUP: next_r.rdata = r.pickup;
                ATC_ADDR_HYST: next_r.rdata = {24'h000000, r.hyst};
                ATC_ADDR_INTERVAL: next_r.rdata = {16'h0000, r.interval};
                ATC_ADDR_PKP_DLY: next_r.rdata = {16'h0000, r.pkp_dly};
                ATC_ADDR_RST_DLY: next_r.rdata = {16'h0000, r.rst_dly};
                ATC_ADDR_BASE: next_r.rdata = {16'h0000, r.cmp_base};
                ATC_ADDR_STATUS: begin
                    next_r.rdata = {28'h0000000, valid, r.drop, r.op, r.pkp};
                end
                ATC_ADDR_IRQ_STAT: next_r.rdata = {28'h0000000, r.irq_stat};
                ATC_ADDR_IRQ_MASK: next_r.rdata = {28'h0000000, r.irq_mask};
                ATC_ADDR_OPVAL: next_r.rdata = r.opval;
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ==================================================
    // Registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r <= '0;
            r.cmp_base <= ATC_RST_BASE;
            r.drop <= 1'b1;
            r.st <= ATC_ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign bus_rdata = r.rdata;
    assign pickup_flag = r.pkp;
    assign operate_flag = r.op;
    assign dropout_flag = r.drop;
    assign irq = r.irq;
endmodule
`default_nettype wire

// ### include/atc_pkg.sv
/*
 Package of the analog threshold comparator: register map, field
 layouts, reset values, mode encodings and timing constants.
 Assumes a 25 MHz ref_clk and a 32-bit plain register port.
*/
`default_nettype none
package atc_pkg;
    localparam int ATC_CLK_HZ = 25000000;
    localparam int ATC_MS_US = 1000;
    localparam int ATC_TICK_US = 1000;
    localparam int ATC_TICK_CYC = (ATC_CLK_HZ / 1000000) * ATC_TICK_US;
    localparam int ATC_HIST_DEPTH = 16;

    localparam logic [7:0] ATC_ADDR_OPSEL = 8'h00;
    localparam logic [7:0] ATC_ADDR_MODE = 8'h04;
    localparam logic [7:0] ATC_ADDR_PICKUP = 8'h08;
    localparam logic [7:0] ATC_ADDR_HYST = 8'h0C;
    localparam logic [7:0] ATC_ADDR_INTERVAL = 8'h10;
    localparam logic [7:0] ATC_ADDR_PKP_DLY = 8'h14;
    localparam logic [7:0] ATC_ADDR_RST_DLY = 8'h18;
    localparam logic [7:0] ATC_ADDR_BASE = 8'h1C;
    localparam logic [7:0] ATC_ADDR_STATUS = 8'h20;
    localparam logic [7:0] ATC_ADDR_IRQ_STAT = 8'h24;
    localparam logic [7:0] ATC_ADDR_IRQ_MASK = 8'h28;
    localparam logic [7:0] ATC_ADDR_OPVAL = 8'h2C;

    localparam int ATC_MODE_ABS_BIT = 0;
    localparam int ATC_MODE_DELTA_BIT = 1;
    localparam int ATC_MODE_UNDER_BIT = 2;
    localparam int ATC_MODE_UNIT_BIT = 3;
    localparam int ATC_IRQ_PKP_BIT = 0;
    localparam int ATC_IRQ_DROP_BIT = 1;
    localparam int ATC_IRQ_OP_BIT = 2;
    localparam int ATC_IRQ_RST_BIT = 3;
    localparam int ATC_IRQ_W = 4;

    localparam logic [31:0] ATC_RST_ZERO = 32'h0000_0000;
    localparam logic [15:0] ATC_RST_BASE = 16'h0100;

    typedef enum logic [3:0] {
        ATC_Q_OFF = 4'h0,
        ATC_Q_FREQ = 4'h1,
        ATC_Q_ANGLE = 4'h2,
        ATC_Q_PF = 4'h3,
        ATC_Q_RTD = 4'h4,
        ATC_Q_DCMA = 4'h5,
        ATC_Q_CURR = 4'h6,
        ATC_Q_VOLT = 4'h7,
        ATC_Q_POWER = 4'h8
    } atc_qtype_t;

    typedef enum logic [1:0] {
        ATC_ST_IDLE = 2'b00,
        ATC_ST_PKP = 2'b01,
        ATC_ST_OP = 2'b10,
        ATC_ST_DROP = 2'b11
    } atc_state_t;

    typedef struct packed {
        logic signed [31:0] value;
        logic [15:0] base;
        atc_qtype_t qtype;
    } atc_operand_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } atc_bus_req_t;
endpackage
`default_nettype wire

// ### verification/atc_monitor.sv
/* Port checker of the threshold comparator.
 Assumes a bind onto atc_comparator and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module atc_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sample_stb,
    input wire atc_pkg::atc_operand_t op_plus,
    input wire atc_pkg::atc_operand_t op_minus,
    input wire atc_pkg::atc_bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    input wire logic pickup_flag,
    input wire logic operate_flag,
    input wire logic dropout_flag,
    input wire logic irq
);
    import atc_pkg::*;
    // ========================================
    // Shadow settings, level mode only
    logic [3:0] mode;
    logic signed [33:0] pkp, hyst, pv, mv, d, s, band;
    logic on, ok, lvl;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode <= 4'h0;
            pkp <= 34'sh0;
            hyst <= 34'sh0;
        end else if (bus_req.wr) begin
            if (bus_req.addr == ATC_ADDR_MODE) begin
                mode <= bus_req.wdata[3:0];
            end
            if (bus_req.addr == ATC_ADDR_PICKUP) begin
                pkp <= {{2{bus_req.wdata[31]}}, bus_req.wdata};
            end
            if (bus_req.addr == ATC_ADDR_HYST) begin
                hyst <= {2'b00, bus_req.wdata};
            end
        end
    end
    assign pv = op_plus.qtype == ATC_Q_OFF ? 34'sh0
        : {{2{op_plus.value[31]}}, op_plus.value};
    assign mv = op_minus.qtype == ATC_Q_OFF ? 34'sh0
        : {{2{op_minus.value[31]}}, op_minus.value};
    assign d = pv - mv;
    assign s = mode[0] && d < 0 ? -d : d;
    assign band = (pkp < 0 ? -pkp : pkp) * hyst / 100;
    assign on = op_plus.qtype != ATC_Q_OFF || op_minus.qtype != ATC_Q_OFF;
    assign ok = on && (op_plus.qtype == op_minus.qtype
        || op_plus.qtype == ATC_Q_OFF || op_minus.qtype == ATC_Q_OFF);
    assign lvl = sample_stb && ok && !mode[1];
    // ========================================
    // Assertions
    property p_over;
        @(posedge ref_clk) disable iff (!rst_n)
        lvl && !mode[2] && s > pkp |=> pickup_flag;
    endproperty
    a_over: assert property (p_over)
        else $error("over pickup missing");
    property p_under;
        @(posedge ref_clk) disable iff (!rst_n)
        lvl && mode[2] && s < pkp |=> pickup_flag;
    endproperty
    a_under: assert property (p_under)
        else $error("under pickup missing");
    property p_drop;
        @(posedge ref_clk) disable iff (!rst_n)
        lvl && !mode[2] && !operate_flag && s < pkp - band |=> !pickup_flag;
    endproperty
    a_drop: assert property (p_drop)
        else $error("no dropout below band");
    property p_none;
        @(posedge ref_clk) disable iff (!rst_n)
        sample_stb && !on |=> !pickup_flag && !operate_flag;
    endproperty
    a_none: assert property (p_none)
        else $error("flag with no operand");
    property p_mix;
        @(posedge ref_clk) disable iff (!rst_n)
        sample_stb && on && !ok |=> !pickup_flag;
    endproperty
    a_mix: assert property (p_mix)
        else $error("flag with mixed types");
    property p_inv;
        @(posedge ref_clk) disable iff (!rst_n)
        dropout_flag != pickup_flag;
    endproperty
    a_inv: assert property (p_inv)
        else $error("dropout not inverse of pickup");
    property p_op;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(operate_flag) |-> pickup_flag;
    endproperty
    a_op: assert property (p_op)
        else $error("operate without pickup");
    property p_stb;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(pickup_flag) |-> $past(sample_stb);
    endproperty
    a_stb: assert property (p_stb)
        else $error("pickup without sample");
endmodule
bind atc_comparator atc_monitor u_atc_monitor (.ref_clk(ref_clk),
    .rst_n(rst_n), .sample_stb(sample_stb), .op_plus(op_plus),
    .op_minus(op_minus), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .pickup_flag(pickup_flag), .operate_flag(operate_flag),
    .dropout_flag(dropout_flag), .irq(irq));
`default_nettype wire

// ### verification/atc_meter.sv
/* Metering source model: strobes one operand pair per request.
 Assumes go is a one-cycle pulse from the bench. */
`timescale 1ns/1ps
`default_nettype none
module atc_meter (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [3:0] lag,
    input wire atc_pkg::atc_qtype_t qp,
    input wire atc_pkg::atc_qtype_t qm,
    input wire logic signed [31:0] vp,
    input wire logic signed [31:0] vm,
    output logic sample_stb,
    output atc_pkg::atc_operand_t op_plus,
    output atc_pkg::atc_operand_t op_minus
);
    import atc_pkg::*;
    // ========================================
    // Lag counter, zero lag answers promptly
    logic [4:0] cnt;
    always_ff @(posedge ref_clk) begin
        sample_stb <= 1'b0;
        if (!rst_n) begin
            cnt <= 5'h00;
            op_plus <= '0;
            op_minus <= '0;
        end else if (go) begin
            cnt <= {1'b1, lag};
        end else if (cnt[4] && cnt[3:0] != 4'h0) begin
            cnt <= cnt - 5'h01;
        end else if (cnt[4]) begin
            cnt <= 5'h00;
            sample_stb <= 1'b1;
            // Off operands carry junk so zeroing is really exercised
            op_plus <= '{value: qp == ATC_Q_OFF ? ~vp : vp,
                base: 16'h0100, qtype: qp};
            op_minus <= '{value: qm == ATC_Q_OFF ? ~vm : vm,
                base: 16'h0100, qtype: qm};
        end
    end
endmodule
`default_nettype wire

// ### verification/atc_comparator_tb.sv
/* Self-checking bench of the threshold comparator.
 Assumes the package map and the metering source model. */
`timescale 1ns/1ps
`default_nettype none
module atc_comparator_tb;
    import atc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic go = 1'b0;
    logic [3:0] lag = 4'h0;
    atc_qtype_t qp = ATC_Q_OFF;
    atc_qtype_t qm = ATC_Q_OFF;
    logic signed [31:0] vp = 32'h0;
    logic signed [31:0] vm = 32'h0;
    atc_bus_req_t req = '0;
    logic stb, pk, op, dp, irq, ia;
    atc_operand_t opp, opm;
    logic [31:0] rdata, r, seed = 32'h0000_CF3B;
    int n_fail = 0;
    int checks = 0;
    int md, pkv, n, a, b, x, y;
    int hv[2][3] = '{'{150, 90, 70}, '{50, 110, 130}};
    atc_meter u_atc_meter (.ref_clk(ref_clk), .rst_n(rst_n), .go(go),
        .lag(lag), .qp(qp), .qm(qm), .vp(vp), .vm(vm),
        .sample_stb(stb), .op_plus(opp), .op_minus(opm));
    atc_comparator u_atc_comparator (.ref_clk(ref_clk), .rst_n(rst_n),
        .sample_stb(stb), .op_plus(opp), .op_minus(opm), .bus_req(req),
        .bus_rdata(rdata), .pickup_flag(pk), .operate_flag(op),
        .dropout_flag(dp), .irq(irq));
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // ========================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic bit ref_pk(int p, int m, int u, int w, int md, int k);
        int s;
        if (p == 0 && m == 0 || p != m && p != 0 && m != 0) return 0;
        s = (p == 0 ? 0 : u) - (m == 0 ? 0 : w);
        if (md[0] && s < 0) s = -s;
        return md[2] ? s < k : s > k;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        @(posedge ref_clk);
        req <= '{addr: ad, wdata: dt, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
        @(posedge ref_clk);
        req <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 dt = rdata;
    endtask
    task automatic send(input int p, input int m, input int u, input int w);
        @(posedge ref_clk);
        r = rnd();
        qp <= atc_qtype_t'(p);
        qm <= atc_qtype_t'(m);
        vp <= u;
        vm <= w;
        lag <= r[3:0];
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (40) begin
            @(posedge ref_clk);
            #1;
            if (stb) break;
        end
        @(posedge ref_clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ========================================
    // Main sequence; long pickup delay keeps operate out of the way
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(ATC_ADDR_PICKUP, r);
        chk("pickup reset", r, ATC_RST_ZERO);
        wr(8'h3C, 32'h5);
        rd(8'h3C, r);
        chk("unmapped", r, 32'h0);
        wr(ATC_ADDR_PKP_DLY, 32'h64);
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            md = int'({r[1], 1'b0, r[0]});
            a = int'(rnd() % 9);
            b = r[2] ? a : int'(rnd() % 9);
            x = int'(rnd() % 801) - 400;
            y = int'(rnd() % 801) - 400;
            pkv = int'(rnd() % 401) - 200;
            wr(ATC_ADDR_MODE, md);
            wr(ATC_ADDR_PICKUP, pkv);
            send(0, 0, 5, 9);
            chk("cleared", {30'h0, pk, op}, 32'h0);
            send(a, b, x, y);
            chk("pickup", {31'h0, pk}, {31'h0, ref_pk(a, b, x, y, md, pkv)});
        end
        wr(ATC_ADDR_HYST, 32'h14);
        wr(ATC_ADDR_PICKUP, 32'h64);
        for (int e = 0; e < 2; e++) begin
            wr(ATC_ADDR_MODE, e * 4);
            send(0, 0, 0, 0);
            for (int k = 0; k < 3; k++) begin
                send(6, 0, hv[e][k], 0);
                chk("band", {31'h0, pk}, {31'h0, k < 2});
            end
        end
        rd(ATC_ADDR_IRQ_STAT, r);
        chk("pickup event", {31'h0, r[ATC_IRQ_PKP_BIT]}, 32'h1);
        wr(ATC_ADDR_IRQ_MASK, 32'h0);
        rd(ATC_ADDR_IRQ_MASK, r);
        ia = irq;
        wr(ATC_ADDR_IRQ_MASK, 32'hF);
        rd(ATC_ADDR_IRQ_MASK, r);
        chk("irq mask", {31'h0, ia ^ irq}, 32'h1);
        wr(ATC_ADDR_IRQ_STAT, 32'hF);
        rd(ATC_ADDR_IRQ_STAT, r);
        chk("irq clear", {r[30:0], irq}, 32'h0);
        wr(ATC_ADDR_MODE, 32'h2);
        wr(ATC_ADDR_PICKUP, 32'h32);
        wr(ATC_ADDR_INTERVAL, 32'h1);
        send(0, 0, 0, 0);
        // Let one interval unit store the zero sample
        repeat (25001) @(posedge ref_clk);
        send(6, 0, 30, 0);
        chk("delta low", {31'h0, pk}, 32'h0);
        send(6, 0, 100, 0);
        chk("delta high", {31'h0, pk}, 32'h1);
        send(0, 0, 0, 0);
        wr(ATC_ADDR_PICKUP, 32'h64);
        wr(ATC_ADDR_MODE, 32'h0);
        wr(ATC_ADDR_PKP_DLY, 32'h2);
        wr(ATC_ADDR_RST_DLY, 32'h2);
        send(6, 0, 150, 0);
        n = 0;
        while (op !== 1'b1 && n < 60000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("pickup delay", {31'h0, n >= 25000 && n <= 50100}, 32'h1);
        send(6, 0, 70, 0);
        chk("reset held", {31'h0, op}, 32'h1);
        n = 0;
        while (op !== 1'b0 && n < 60000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk("reset delay", {31'h0, n >= 24900 && n <= 50100}, 32'h1);
        print_verdict();
    end
    initial begin
        #8_000_000;
        n_fail++;
        print_verdict();
    end
endmodule
`default_nettype wire
